// [logic/fiber_status_prbs_map.svh]
/*
  Register indices, field positions, reset values and counts of the
  fiber status and pattern test block.
  Assumes a byte-addressed bus; each register index is one 32-bit word.
*/
`ifndef FIBER_STATUS_PRBS_MAP_SVH
`define FIBER_STATUS_PRBS_MAP_SVH

`define IDX_EVENT_STATUS   6'h13
`define IDX_RX_TALLY       6'h15
`define IDX_PATTERN_CTRL   6'h17
`define IDX_ERR_LOW        6'h18
`define IDX_ERR_HIGH       6'h19
`define IDX_IRQ_MASK       6'h1A
`define IDX_IRQ_STATUS     6'h1B

`define EV_SPEED           14
`define EV_DUPLEX          13
`define EV_PAGE            12
`define EV_NEG_DONE        11
`define EV_LINK            10
`define EV_SYMBOL          9
`define EV_FALSE_CARRIER   8
`define EV_FIFO            7
`define EV_ENERGY          4
`define EV_LIVE_MASK       16'h7F90

`define CTL_INV_CHECKER    7
`define CTL_INV_GENERATOR  6
`define CTL_LOCK           5
`define CTL_CLEAR          4
`define CTL_SEL_HI         3
`define CTL_SEL_LO         2
`define CTL_CHK_EN         1
`define CTL_GEN_EN         0

`define SEL_PRBS7          2'h0
`define SEL_PRBS23         2'h1
`define SEL_PRBS31         2'h2
`define SEL_ALTERNATE      2'h3

`define RST_WORD           16'h0000
`define RST_ENERGY_IDLE    1'h1
`define TALLY_MAX          16'hFFFF
`define PRBS_SEED          31'h7FFF_FFFF
`define LOCK_RUN_DEFAULT   32

`endif

// [logic/fiber_status_prbs_pkg.sv]
/*
  Types of the fiber status and pattern test block.
  Assumes the constants of fiber_status_prbs_map.svh.
*/
package fiber_status_prbs_pkg;

  typedef struct packed {
    logic [1:0] speed;         // Resolved speed, level
    logic       duplex;        // Resolved duplex, level
    logic       link;          // Link state, level
    logic       energy_idle;   // 1 = no energy, level
    logic       page_rx;       // Page received, pulse
    logic       neg_done;      // Negotiation completed, pulse
    logic       symbol_err;    // Symbol error, pulse
    logic       false_carrier; // False carrier, pulse
    logic       fifo_err;      // Elastic FIFO over/underflow, pulse
  } fiber_events_type;

  typedef struct packed {
    logic        waitreq;
    logic [31:0] rdata;
    logic [15:0] events;
    logic [15:0] rx_tally;
    logic [15:0] ctrl;
    logic [31:0] err_cnt;
    logic [15:0] err_high;
    logic [15:0] irq_status;
    logic [15:0] irq_mask;
    logic        irq;
    logic [30:0] gen;
    logic [30:0] chk;
    logic [7:0]  run;
    logic        locked;
    logic        tx_bit;
    logic [1:0]  prev_speed;
    logic        prev_duplex;
    logic        prev_link;
    logic        prev_energy;
  } state_type;

endpackage

// [logic/fiber_status_prbs_test.sv]
/*
  Fiber status and pattern test block: latched event flags, a saturating
  receive error tally, a pattern generator and checker with a 32-bit error
  counter, and an interrupt built from the event flags.
  Assumes event inputs and the receive bit come from logic on clock_i and
  that an Avalon-MM master with waitrequest reaches the registers.
*/
// Local design decision: the Avalon-MM slave port.
// Overview of operation
// - Speed change sets bit 14, duplex change sets bit 13; flags hold.
// - Page received latches bit 12, negotiation completed latches bit 11.
// - Any change of link state latches bit 10.
// - Symbol error latches bit 9, false carrier latches bit 8.
// - Elastic FIFO overflow or underflow latches bit 7.
// - Energy-detect change latches bit 4; bits 15, 6:5, 3:0 read zero.
// - The 16-bit receive error tally stops at its maximum, never wraps.
// - Both false carrier and symbol error advance the receive error tally.
// - With bit 5 set, error counting waits for the checker's first lock.
// - Writing one to clear bit 4 zeroes both counter halves, nothing else.
// - Pattern code 11 makes the generator emit alternating ones and zeroes.
// - Codes 10, 01, 00 select PRBS31, PRBS23 and PRBS7 polynomials.
// - Reading the low half snapshots the high half for coherent reads.
`timescale 1ns/10ps
`include "fiber_status_prbs_map.svh"

module fiber_status_prbs_test #(
  parameter int unsigned LOCK_RUN = `LOCK_RUN_DEFAULT
) (
  input  wire logic                                 clock_i,       // 20 MHz clock
  input  wire logic                                 sys_rst_i,     // Sync reset, high
  input  wire logic                                 sw_rst_i,      // Software reset pulse
  input  wire fiber_status_prbs_pkg::fiber_events_type ev_i,       // Receive-side events
  input  wire logic                                 rx_data_i,     // Received serial bit
  input  wire logic [7:0]                           address_i,     // Avalon byte address
  input  wire logic                                 read_i,        // Avalon read
  input  wire logic                                 write_i,       // Avalon write
  input  wire logic [31:0]                          writedata_i,   // Avalon write data
  input  wire logic [3:0]                           byteenable_i,  // Avalon byte enables
  output logic [31:0]                               readdata_o,    // Avalon read data
  output logic                                      waitrequest_o, // Avalon wait
  output logic                                      irq_o,         // Level interrupt
  output logic                                      tx_data_o,     // Generated serial bit
  output logic                                      locked_o       // Checker has locked
);

  fiber_status_prbs_pkg::state_type s;
  fiber_status_prbs_pkg::state_type next_s;

  localparam fiber_status_prbs_pkg::state_type RESET_STATE = '{
    waitreq:     1'b1,
    rdata:       {`RST_WORD, `RST_WORD},
    events:      `RST_WORD,
    rx_tally:    `RST_WORD,
    ctrl:        `RST_WORD,
    err_cnt:     {`RST_WORD, `RST_WORD},
    err_high:    `RST_WORD,
    irq_status:  `RST_WORD,
    irq_mask:    `RST_WORD,
    irq:         1'b0,
    gen:         `PRBS_SEED,
    chk:         31'h0000_0000,
    run:         8'h00,
    locked:      1'b0,
    tx_bit:      1'b0,
    prev_speed:  2'h0,
    prev_duplex: 1'b0,
    prev_link:   1'b0,
    prev_energy: `RST_ENERGY_IDLE
  };

  localparam logic [7:0] LAST_RUN = 8'(LOCK_RUN - 1);

  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx);
  endfunction

  // Feedback bit of the selected pattern; shared by generator and checker
  function automatic logic pattern_fb(input logic [30:0] st, input logic [1:0] sel);
    case (sel)
      `SEL_PRBS31:    pattern_fb = st[30] ^ st[27];
      `SEL_PRBS23:    pattern_fb = st[22] ^ st[17];
      `SEL_PRBS7:     pattern_fb = st[6] ^ st[5];
      `SEL_ALTERNATE: pattern_fb = ~st[0];
      default:        pattern_fb = 1'b0;
    endcase
  endfunction

  // Bus phases: the request is decoded in its first cycle, acted on in the second
  logic        rd_take;
  logic        rd_acc;
  logic        wr_acc;
  logic        rd_events;
  logic        rd_tally;
  logic        wr_ctrl;
  logic        clear_cnt;
  logic [1:0]  sel;
  logic        chk_en;
  logic        gen_en;
  logic        chk_din;
  logic        mismatch;
  logic        count_ok;
  logic [15:0] ev_set;
  logic [15:0] w1c;
  logic [15:0] tally_base;

  assign rd_take   = read_i && s.waitreq;
  assign rd_acc    = read_i && !s.waitreq;
  assign wr_acc    = write_i && !s.waitreq;
  assign rd_events = rd_acc && hit(address_i, `IDX_EVENT_STATUS);
  assign rd_tally  = rd_acc && hit(address_i, `IDX_RX_TALLY);
  assign wr_ctrl   = wr_acc && hit(address_i, `IDX_PATTERN_CTRL) && byteenable_i[0];
  assign clear_cnt = wr_ctrl && writedata_i[`CTL_CLEAR];
  assign sel       = s.ctrl[`CTL_SEL_HI:`CTL_SEL_LO];
  assign chk_en    = s.ctrl[`CTL_CHK_EN];
  assign gen_en    = s.ctrl[`CTL_GEN_EN];
  assign chk_din   = rx_data_i ^ s.ctrl[`CTL_INV_CHECKER];
  assign mismatch  = chk_en && (pattern_fb(s.chk, sel) != chk_din);
  assign count_ok  = !s.ctrl[`CTL_LOCK] || s.locked;

  always_comb begin
    ev_set = `RST_WORD;
    ev_set[`EV_SPEED]         = ev_i.speed != s.prev_speed;
    ev_set[`EV_DUPLEX]        = ev_i.duplex != s.prev_duplex;
    ev_set[`EV_PAGE]          = ev_i.page_rx;
    ev_set[`EV_NEG_DONE]      = ev_i.neg_done;
    ev_set[`EV_LINK]          = ev_i.link != s.prev_link;
    ev_set[`EV_SYMBOL]        = ev_i.symbol_err;
    ev_set[`EV_FALSE_CARRIER] = ev_i.false_carrier;
    ev_set[`EV_FIFO]          = ev_i.fifo_err;
    ev_set[`EV_ENERGY]        = ev_i.energy_idle != s.prev_energy;
  end

  always_comb begin
    w1c = `RST_WORD;
    if (wr_acc && hit(address_i, `IDX_IRQ_STATUS)) begin
      w1c[7:0]  = byteenable_i[0] ? writedata_i[7:0] : 8'h00;
      w1c[15:8] = byteenable_i[1] ? writedata_i[15:8] : 8'h00;
    end
  end

  always_comb begin
    next_s = s;
    // Only the reported count is removed; counts taken during the wait cycle stay
    tally_base = rd_tally ? s.rx_tally - s.rdata[15:0] : s.rx_tally;

    // One wait cycle, then the answer; readdata is ready with waitrequest low
    next_s.waitreq = !((read_i || write_i) && s.waitreq);
    next_s.rdata = {`RST_WORD, `RST_WORD};
    if (rd_take) begin
      if (hit(address_i, `IDX_EVENT_STATUS)) begin
        next_s.rdata[15:0] = s.events & `EV_LIVE_MASK;
      end else if (hit(address_i, `IDX_RX_TALLY)) begin
        next_s.rdata[15:0] = s.rx_tally;
      end else if (hit(address_i, `IDX_PATTERN_CTRL)) begin
        next_s.rdata[15:0] = s.ctrl;
      end else if (hit(address_i, `IDX_ERR_LOW)) begin
        next_s.rdata[15:0] = s.err_cnt[15:0];
      end else if (hit(address_i, `IDX_ERR_HIGH)) begin
        next_s.rdata[15:0] = s.err_high;
      end else if (hit(address_i, `IDX_IRQ_MASK)) begin
        next_s.rdata[15:0] = s.irq_mask;
      end else if (hit(address_i, `IDX_IRQ_STATUS)) begin
        next_s.rdata[15:0] = s.irq_status;
      end
    end

    // Change detectors track the live levels every cycle
    next_s.prev_speed  = ev_i.speed;
    next_s.prev_duplex = ev_i.duplex;
    next_s.prev_link   = ev_i.link;
    next_s.prev_energy = ev_i.energy_idle;

    // Read clear drops only the flags that were reported; later events survive
    if (sw_rst_i) begin
      next_s.events = `RST_WORD;
    end else if (rd_events) begin
      next_s.events = ((s.events & ~s.rdata[15:0]) | ev_set) & `EV_LIVE_MASK;
    end else begin
      next_s.events = (s.events | ev_set) & `EV_LIVE_MASK;
    end

    // Increment of the read-clear cycle lands on the cleared tally
    if ((ev_i.symbol_err || ev_i.false_carrier) && tally_base != `TALLY_MAX) begin
      next_s.rx_tally = tally_base + 16'h0001;
    end else begin
      next_s.rx_tally = tally_base;
    end

    next_s.irq_status = ((s.irq_status & ~w1c) | ev_set) & `EV_LIVE_MASK;
    if (wr_acc && hit(address_i, `IDX_IRQ_MASK)) begin
      if (byteenable_i[0]) begin
        next_s.irq_mask[7:0] = writedata_i[7:0];
      end
      if (byteenable_i[1]) begin
        next_s.irq_mask[15:8] = writedata_i[15:8];
      end
    end

    // Clear bit is self-clearing: it never holds in the stored word
    if (wr_ctrl) begin
      next_s.ctrl[7:0] = writedata_i[7:0];
      next_s.ctrl[`CTL_CLEAR] = 1'b0;
    end
    if (wr_acc && hit(address_i, `IDX_PATTERN_CTRL) && byteenable_i[1]) begin
      next_s.ctrl[15:8] = writedata_i[15:8];
    end
    if (sw_rst_i) begin
      next_s.ctrl[`CTL_CHK_EN] = 1'b0;
      next_s.ctrl[`CTL_GEN_EN] = 1'b0;
    end

    // Generator restarts from the seed each time it is enabled
    if (gen_en) begin
      next_s.gen = {s.gen[29:0], pattern_fb(s.gen, sel)};
      next_s.tx_bit = pattern_fb(s.gen, sel) ^ s.ctrl[`CTL_INV_GENERATOR];
    end else begin
      next_s.gen = `PRBS_SEED;
      next_s.tx_bit = 1'b0;
    end

    // Checker self-synchronises by shifting in the received bits
    if (chk_en) begin
      next_s.chk = {s.chk[29:0], chk_din};
      if (mismatch) begin
        next_s.run = 8'h00;
      end else if (s.run != LAST_RUN) begin
        next_s.run = s.run + 8'h01;
      end else begin
        next_s.locked = 1'b1;
      end
    end else begin
      next_s.chk = 31'h0000_0000;
      next_s.run = 8'h00;
      next_s.locked = 1'b0;
    end

    // Counter wraps at 32 bits; apart from sys_rst_i, only the clear bit resets it
    if (clear_cnt) begin
      next_s.err_cnt = {`RST_WORD, `RST_WORD};
      next_s.err_high = `RST_WORD;
    end else begin
      if (mismatch && count_ok) begin
        next_s.err_cnt = s.err_cnt + 32'h0000_0001;
      end
      if (rd_take && hit(address_i, `IDX_ERR_LOW)) begin
        next_s.err_high = s.err_cnt[31:16];
      end
    end

    next_s.irq = |(next_s.irq_status & next_s.irq_mask);
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s <= RESET_STATE;
    end else begin
      s <= next_s;
    end
  end

  assign readdata_o    = s.rdata;
  assign waitrequest_o = s.waitreq;
  assign irq_o         = s.irq;
  assign tx_data_o     = s.tx_bit;
  assign locked_o      = s.locked;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  a_speed_change_flag: assert property (ev_i.speed != s.prev_speed && !sw_rst_i |=> s.events[14])
    else $error("speed change did not latch its flag");
  a_page_rx_flag: assert property (ev_i.page_rx && !sw_rst_i |=> s.events[12] ##0 s.irq_status[12])
    else $error("page received did not latch");
  a_link_change_flag: assert property (ev_i.link != $past(ev_i.link) && !sw_rst_i |=> s.events[10])
    else $error("link change did not latch");
  a_false_carrier_flag: assert property (ev_i.false_carrier && !sw_rst_i |=> s.events[8])
    else $error("false carrier did not latch");
  a_fifo_error_flag: assert property (ev_i.fifo_err && !sw_rst_i |=> s.events[7])
    else $error("fifo error did not latch");
  a_reserved_bits_zero: assert property ((s.events & ~`EV_LIVE_MASK) == 16'h0000)
    else $error("reserved event bits are set");
  a_tally_read_clear: assert property (rd_tally && !ev_i.symbol_err && !ev_i.false_carrier
      |=> s.rx_tally == $past(s.rx_tally) - $past(s.rdata[15:0]))
    else $error("tally did not clear on read");
  a_tally_saturates: assert property (s.rx_tally == 16'hFFFF && !rd_tally |=> s.rx_tally == 16'hFFFF)
    else $error("tally wrapped");
  a_tally_counts: assert property ((ev_i.symbol_err || ev_i.false_carrier) && !rd_tally
      && s.rx_tally != 16'hFFFF |=> s.rx_tally == $past(s.rx_tally) + 16'h0001)
    else $error("tally did not advance");
  a_lock_holds_count: assert property (s.ctrl[5] && !s.locked && !clear_cnt
      |=> s.err_cnt == $past(s.err_cnt))
    else $error("counted before first lock");
  a_clear_both_halves: assert property (clear_cnt |=> s.err_cnt == 32'h0000_0000 && s.err_high == 16'h0000)
    else $error("clear bit did not zero counter");
  a_alternate_toggles: assert property (gen_en && sel == 2'h3 && !s.ctrl[6] ##1
      gen_en && sel == 2'h3 && !s.ctrl[6] |=> s.tx_bit != $past(s.tx_bit))
    else $error("alternate pattern did not toggle");
  a_high_snapshot: assert property (rd_take && hit(address_i, 6'h18) && !clear_cnt
      |=> s.err_high == $past(s.err_cnt[31:16]))
    else $error("high half not captured");
  a_sw_reset_disables: assert property (sw_rst_i |=> s.ctrl[1:0] == 2'h0 ##1 !s.locked)
    else $error("software reset left pattern logic enabled");

endmodule

// [verif/fiber_link_partner.sv]
/*
  Loopback link partner: returns the transmitted serial bit one clock
  later, optionally inverted to model a line that corrupts every bit.
  Assumes one clock shared with the block under test.
*/
`timescale 1ns/10ps
module fiber_link_partner (
  input  wire logic clock_i,   // Device clock
  input  wire logic tx_data_i, // Bit from the generator
  input  wire logic flip_i,    // Invert the returned bit
  output logic      rx_data_o  // Bit back to the checker
);
  // Registered so the checker sees a real line delay, not a wire
  always_ff @(posedge clock_i) begin
    rx_data_o <= tx_data_i ^ flip_i;
  end
endmodule

// [verif/test_fiber_status_prbs_test.sv]
/*
  Self-checking bench of the fiber status and pattern test block.
  Assumes the map header on the include path and the loopback partner.
*/
`timescale 1ns/10ps
`include "fiber_status_prbs_map.svh"
module test_fiber_status_prbs_test;
  logic        clock_i   = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        sw_rst    = 1'b0;
  logic [9:0]  ev        = 10'h020;
  logic [7:0]  address   = 8'h00;
  logic        read      = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic        flip      = 1'b0;
  logic [63:0] hist      = '0;
  logic [31:0] seed      = 32'h92d6_9a17;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic        waitrequest;
  logic        irq;
  logic        tx_data;
  logic        rx_data;
  logic        locked;
  int          n_fail    = 0;
  int          cmp_count = 0;
  int          cycles    = 0;

  fiber_status_prbs_test #(.LOCK_RUN(4)) DUT (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sw_rst_i(sw_rst),
    .ev_i(fiber_status_prbs_pkg::fiber_events_type'(ev)), .rx_data_i(rx_data),
    .address_i(address), .read_i(read), .write_i(write), .writedata_i(writedata),
    .byteenable_i(4'hF), .readdata_o(readdata), .waitrequest_o(waitrequest),
    .irq_o(irq), .tx_data_o(tx_data), .locked_o(locked));

  fiber_link_partner partner (
    .clock_i(clock_i), .tx_data_i(tx_data), .flip_i(flip), .rx_data_o(rx_data));

  always #25 clock_i = ~clock_i;

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Newest transmitted bit lands in hist[0]
  always @(posedge clock_i) begin
    hist <= {hist[62:0], tx_data};
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock_i);
    address <= a;
    writedata <= wd;
    write <= we;
    read <= ~we;
    do @(posedge clock_i); while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic pulse_sw;
    @(posedge clock_i);
    sw_rst <= 1'b1;
    @(posedge clock_i);
    sw_rst <= 1'b0;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return (x >> 1) ^ (x[0] ? 32'hA300_0000 : 32'h0000_0000);
  endfunction

  // Any toggle of an event input, level or pulse, leaves its flag set
  function automatic logic [31:0] flags_of(input logic [9:0] x);
    logic [31:0] f;
    f = 32'h0000_0000;
    f[`EV_SPEED] = |x[9:8];
    f[`EV_DUPLEX] = x[7];
    f[`EV_LINK] = x[6];
    f[`EV_ENERGY] = x[5];
    f[`EV_PAGE] = x[4];
    f[`EV_NEG_DONE] = x[3];
    f[`EV_SYMBOL] = x[2];
    f[`EV_FALSE_CARRIER] = x[1];
    f[`EV_FIFO] = x[0];
    return f;
  endfunction

  // Checks the output recurrence, so the shift direction inside does not matter
  function automatic int recur_bad(input logic [1:0] sel, input logic inv);
    int p;
    int q;
    int bad;
    p = sel == 2'h0 ? 7 : sel == 2'h1 ? 23 : 31;
    q = sel == 2'h0 ? 6 : sel == 2'h1 ? 18 : 28;
    bad = 0;
    for (int i = 0; i < 64 - p; i++) begin
      if (sel == 2'h3 ? hist[i] === hist[i+1] : hist[i] !== (hist[i+p] ^ hist[i+q] ^ inv))
        bad++;
    end
    return bad;
  endfunction

  initial begin
    int          k;
    logic [9:0]  x;
    logic [31:0] cw;
    tick(16);
    sys_rst_i <= 1'b0;
    for (k = 0; k < 9; k++) begin
      rdchk(8'h4C + 8'(4 * k), 32'h0000_0000);
    end
    for (k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      x = (k == 0) ? 10'h3FF : seed[9:0];
      @(posedge clock_i);
      ev <= ev ^ x;
      @(posedge clock_i);
      ev <= ev ^ x;
      rdchk(8'h4C, flags_of(x));
      rdchk(8'h4C, 32'h0000_0000);
    end
    bus(1'b0, 8'h54, 32'h0000_0000);
    @(posedge clock_i);
    ev <= 10'h024;
    tick(3);
    ev <= 10'h022;
    tick(2);
    ev <= 10'h020;
    rdchk(8'h54, 32'h0000_0005);
    rdchk(8'h54, 32'h0000_0000);
    ev <= 10'h024;
    tick(65540);
    ev <= 10'h020;
    rdchk(8'h54, 32'h0000_FFFF);
    bus(1'b1, 8'h6C, 32'h0000_FFFF);
    bus(1'b1, 8'h68, 32'h0000_0200);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    ev <= 10'h024;
    @(posedge clock_i);
    ev <= 10'h020;
    tick(2);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, 8'h68, 32'h0000_0000);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, 8'h68, 32'h0000_0200);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, 8'h6C, 32'h0000_0200);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, 8'h5C, 32'h0000_00A3);
    pulse_sw();
    rdchk(8'h4C, 32'h0000_0000);
    rdchk(8'h5C, 32'h0000_00A0);
    for (k = 0; k < 8; k++) begin
      cw = {24'h0, k[2], k[2], 2'b00, k[1:0], 2'b11};
      bus(1'b1, 8'h5C, cw);
      tick(70);
      bus(1'b1, 8'h5C, cw | 32'h0000_0010);
      tick(40);
      chk(32'(recur_bad(k[1:0], k[2])), 32'h0000_0000);
      chk({31'h0, locked}, 32'h0000_0001);
      rdchk(8'h60, 32'h0000_0000);
      rdchk(8'h64, 32'h0000_0000);
    end
    // An inverted line never matches, so the checker can never lock
    flip <= 1'b1;
    bus(1'b1, 8'h5C, 32'h0000_0000);
    bus(1'b1, 8'h5C, 32'h0000_0033);
    tick(40);
    chk({31'h0, locked}, 32'h0000_0000);
    rdchk(8'h60, 32'h0000_0000);
    bus(1'b1, 8'h5C, 32'h0000_0003);
    tick(40);
    bus(1'b0, 8'h60, 32'h0000_0000);
    chk({31'h0, rd[15:0] > 16'h0020}, 32'h0000_0001);
    rdchk(8'h64, 32'h0000_0000);
    pulse_sw();
    bus(1'b0, 8'h60, 32'h0000_0000);
    cw = rd;
    chk({31'h0, cw[15:0] > 16'h0020}, 32'h0000_0001);
    bus(1'b1, 8'h60, 32'h0000_0000);
    rdchk(8'h60, cw);
    bus(1'b1, 8'h5C, 32'h0000_0010);
    flip <= 1'b0;
    rdchk(8'h60, 32'h0000_0000);
    rdchk(8'h64, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
